// [core/ssmc_pkg.sv]
/*
  Constants, types and register map of the supply supervisor mode control block.
  Assumes a 125 MHz clock and an AXI4-Lite master with 32-bit data.
*/
// Functional notes
// (RQ1) normal low supervisor settles about 150 us
// (RQ2) full-performance low supervisor settles about 2 us
// (RQ3) software waits settle flags clear before sleeping
// (RQ4) low full-perf cleared gives slow 150 us wake
// (RQ5) low units off or full: fast wake
// (RQ6) any low unit normal: slow wake
// (RQ7) deep sleep by request or ISR exit
// (RQ8) low events raise reset or interrupt, configurable
// (RQ9) overvoltage enable: supply monitor forces power-on reset
// (RQ10) high auto: normal supply monitor off asleep
// (RQ11) some high settings turn normal to off
// (RQ12) software should keep high units manual, on
// (RQ13) disabled unit off; enabled: full or normal
// (RQ14) deep sleep: manual keep bit, auto demotes
package ssmc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 125;
  localparam int SLOW_SETTLE_US = 150;
  localparam int FAST_SETTLE_US = 2;
  localparam int SLOW_CYC_DEF   = SLOW_SETTLE_US * CLK_MHZ;
  localparam int FAST_CYC       = FAST_SETTLE_US * CLK_MHZ;
  localparam int CNT_W          = 15;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_LOW_CTRL = 8'h00;
  localparam logic [7:0]  OFF_HIGH_CTRL = 8'h04;
  localparam logic [7:0]  OFF_PWR_CTRL = 8'h08;
  localparam logic [7:0]  OFF_STATUS   = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0]  OFF_IRQ_CLR  = 8'h14;
  localparam logic [7:0]  OFF_IRQ_EN   = 8'h18;

  // control fields, same layout on both sides
  localparam int B_SUP_EN    = 0;
  localparam int B_SUP_KEEP  = 1;
  localparam int B_SUP_FP    = 2;
  localparam int B_MON_EN    = 3;
  localparam int B_MON_FP    = 4;
  localparam int B_AUTO      = 5;
  localparam int B_SUP_RST   = 6;
  localparam int B_MON_RST   = 7;
  localparam int B_OVP_EN    = 8;
  localparam int CTRL_W      = 9;
  // power control fields
  localparam int B_ISR_SLEEP = 0;
  localparam int B_SLEEP_REQ = 1;
  localparam int B_CORE_LO   = 2;
  // status fields
  localparam int B_ST_LSET   = 0;
  localparam int B_ST_HSET   = 1;
  localparam int B_ST_DEEP   = 2;
  localparam int B_ST_FAST   = 3;
  localparam int B_ST_HOLD   = 4;
  localparam int B_ST_UNITS  = 8;
  // interrupt fields
  localparam int EV_LOW_SUP  = 0;
  localparam int EV_LOW_MON  = 1;
  localparam int EV_HIGH_SUP = 2;
  localparam int EV_HIGH_MON = 3;
  localparam int EV_SETTLED  = 4;
  localparam int EV_W        = 5;

  // reset values
  localparam logic [CTRL_W-1:0] RST_LOW_CTRL  = 9'h003;
  localparam logic [CTRL_W-1:0] RST_HIGH_CTRL = 9'h0CB;
  localparam logic [3:0]        RST_PWR_CTRL  = 4'h0;
  localparam logic [EV_W-1:0]   RST_IRQ_EN    = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SSMC_OFF  = 3'b001,
    SSMC_NORM = 3'b010,
    SSMC_FULL = 3'b100
  } ssmc_mode_t;

  typedef enum logic [2:0] {
    PS_ACTIVE = 3'b001,
    PS_DEEP   = 3'b010,
    PS_WAKE   = 3'b100
  } ssmc_pwr_t;

  typedef struct packed {
    ssmc_mode_t low_sup;
    ssmc_mode_t low_mon;
    ssmc_mode_t high_sup;
    ssmc_mode_t high_mon;
  } ssmc_units_t;

  typedef struct packed {
    logic en;
    logic keep;
    logic fp;
    logic auto_ctl;
  } ssmc_unit_cfg_t;

  typedef struct packed {
    logic low_sup;
    logic low_mon;
    logic high_sup;
    logic high_mon;
    logic supply_ovp;
  } ssmc_trips_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } ssmc_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ssmc_axi_rsp_t;

endpackage

// [core/ssmc_top.sv]
/*
  Supply supervisor mode control: AXI4-Lite registers, settle timers, sleep and
  wake sequencing, event routing to power-on reset or interrupt.
  Assumes comparator trip inputs synchronous to i_mclk and a single AXI master.
*/
`timescale 1ns/1ps
module ssmc_top #(
  parameter int SLOW_CYC = ssmc_pkg::SLOW_CYC_DEF
) (
  // clock and reset
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  // register bus
  input  wire ssmc_pkg::ssmc_axi_req_t i_axi,
  output ssmc_pkg::ssmc_axi_rsp_t     o_axi,
  // system events
  input  wire ssmc_pkg::ssmc_trips_t  i_trips,
  input  wire logic                   i_isr_done,
  input  wire logic                   i_wake,
  // results
  output ssmc_pkg::ssmc_units_t       o_units,
  output logic                        o_deep_sleep,
  output logic                        o_cpu_hold,
  output logic                        o_fast_wake,
  output logic                        o_por,
  output logic                        o_irq
);
  import ssmc_pkg::*;

  localparam logic [CNT_W-1:0] FAST_CNT = CNT_W'(FAST_CYC);
  localparam logic [CNT_W-1:0] SLOW_CNT = CNT_W'(SLOW_CYC);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [CTRL_W-1:0] low_ctrl;
    logic [CTRL_W-1:0] high_ctrl;
    logic [3:0]        pwr_ctrl;
    logic [EV_W-1:0]   irq_en;
    logic [EV_W-1:0]   irq_stat;
    logic              low_settle;
    logic              high_settle;
    logic [CNT_W-1:0]  low_cnt;
    logic [CNT_W-1:0]  high_cnt;
    ssmc_pwr_t         pwr;
    logic [CNT_W-1:0]  wake_cnt;
    logic              fast_wake;
    ssmc_units_t       units;
    logic              por;
  } ssmc_state_t;

  ssmc_state_t    st_r;
  ssmc_state_t    st_nxt;
  ssmc_units_t    units_dec;
  ssmc_unit_cfg_t cfg_ls;
  ssmc_unit_cfg_t cfg_lm;
  ssmc_unit_cfg_t cfg_hs;
  ssmc_unit_cfg_t cfg_hm;
  logic           wr_go;
  logic           rd_go;
  logic [31:0]    wr_val;
  logic [31:0]    status_w;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic ssmc_unit_cfg_t sup_cfg(input logic [CTRL_W-1:0] c);
    return '{en: c[B_SUP_EN], keep: c[B_SUP_KEEP], fp: c[B_SUP_FP], auto_ctl: c[B_AUTO]};
  endfunction

  // monitors have no keep bit: in manual control they stay as in active mode
  function automatic ssmc_unit_cfg_t mon_cfg(input logic [CTRL_W-1:0] c);
    return '{en: c[B_MON_EN], keep: 1'b1, fp: c[B_MON_FP], auto_ctl: c[B_AUTO]};
  endfunction

  // settle time depends on the supervisor's performance setting
  function automatic logic [CNT_W-1:0] settle_load(input logic [CTRL_W-1:0] c);
    return (c[B_SUP_EN] && c[B_SUP_FP]) ? FAST_CNT : SLOW_CNT;
  endfunction

  function automatic logic [31:0] reg_word(input ssmc_state_t s, input logic [ADDR_W-1:0] a);
    case (a)
      OFF_LOW_CTRL:  return {{(32-CTRL_W){1'b0}}, s.low_ctrl};
      OFF_HIGH_CTRL: return {{(32-CTRL_W){1'b0}}, s.high_ctrl};
      OFF_PWR_CTRL:  return {28'h0000000, s.pwr_ctrl & 4'hD};
      OFF_IRQ_EN:    return {27'h0000000, s.irq_en};
      default:       return 32'h00000000;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == OFF_LOW_CTRL) || (a == OFF_HIGH_CTRL) || (a == OFF_PWR_CTRL) ||
           (a == OFF_STATUS) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_CLR) || (a == OFF_IRQ_EN);
  endfunction

  // ----------------------------------------------------------------
  // unit mode decode
  // ----------------------------------------------------------------
  assign cfg_ls = sup_cfg(st_r.low_ctrl);
  assign cfg_lm = mon_cfg(st_r.low_ctrl);
  assign cfg_hs = sup_cfg(st_r.high_ctrl);
  assign cfg_hm = mon_cfg(st_r.high_ctrl);

  ssmc_unit_mode u_low_sup  (.i_cfg(cfg_ls), .i_deep(st_r.pwr == PS_DEEP), .o_mode(units_dec.low_sup));
  ssmc_unit_mode u_low_mon  (.i_cfg(cfg_lm), .i_deep(st_r.pwr == PS_DEEP), .o_mode(units_dec.low_mon));
  ssmc_unit_mode u_high_sup (.i_cfg(cfg_hs), .i_deep(st_r.pwr == PS_DEEP), .o_mode(units_dec.high_sup));
  ssmc_unit_mode u_high_mon (.i_cfg(cfg_hm), .i_deep(st_r.pwr == PS_DEEP), .o_mode(units_dec.high_mon));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign wr_go  = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_go  = i_axi.arvalid && !st_r.rvalid;
  assign wr_val = merge_strb(reg_word(st_r, st_r.awaddr), st_r.wdata, st_r.wstrb);
  assign status_w = {12'h000, st_r.units, 3'h0, st_r.pwr == PS_WAKE, st_r.fast_wake,
                     st_r.pwr == PS_DEEP, st_r.high_settle, st_r.low_settle};

  always_comb begin
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic            lo_load;
    logic            hi_load;
    logic            sleep_go;
    ev       = '0;
    clr      = '0;
    lo_load  = 1'b0;
    hi_load  = 1'b0;
    sleep_go = 1'b0;
    st_nxt   = st_r;
    st_nxt.por = 1'b0;

    // bus: address and data taken in either order, answered once both held
    if (i_axi.awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_axi.awaddr;
    end
    if (i_axi.wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_axi.wdata;
      st_nxt.wstrb = i_axi.wstrb;
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = addr_ok(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (st_r.awaddr)
        OFF_LOW_CTRL: begin
          st_nxt.low_ctrl = wr_val[CTRL_W-1:0];
          lo_load = 1'b1;
        end
        OFF_HIGH_CTRL: begin
          st_nxt.high_ctrl = wr_val[CTRL_W-1:0];
          hi_load = 1'b1;
        end
        OFF_PWR_CTRL: begin
          st_nxt.pwr_ctrl = {wr_val[3:2], 1'b0, wr_val[B_ISR_SLEEP]};
          // a core level change restarts the low side settle window
          lo_load  = (wr_val[3:2] != st_r.pwr_ctrl[3:2]);
          sleep_go = wr_val[B_SLEEP_REQ];
        end
        OFF_IRQ_CLR: clr = wr_val[EV_W-1:0];
        OFF_IRQ_EN:  st_nxt.irq_en = wr_val[EV_W-1:0];
        default: begin
        end
      endcase
    end
    if (st_r.bvalid && i_axi.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = addr_ok(i_axi.araddr) ? RESP_OKAY : RESP_SLVERR;
      case (i_axi.araddr)
        OFF_STATUS:   st_nxt.rdata = status_w;
        OFF_IRQ_STAT: st_nxt.rdata = {27'h0000000, st_r.irq_stat};
        default:      st_nxt.rdata = reg_word(st_r, i_axi.araddr);
      endcase
    end else if (st_r.rvalid && i_axi.rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // settle timers
    if (lo_load) begin
      st_nxt.low_settle = 1'b1;
      st_nxt.low_cnt    = settle_load(st_nxt.low_ctrl);                     // [RQ1] [RQ2]
    end else if (st_r.low_settle) begin
      st_nxt.low_cnt    = st_r.low_cnt - 1'b1;
      st_nxt.low_settle = (st_r.low_cnt != 1);
    end
    if (hi_load) begin
      st_nxt.high_settle = 1'b1;
      st_nxt.high_cnt    = settle_load(st_nxt.high_ctrl);
    end else if (st_r.high_settle) begin
      st_nxt.high_cnt    = st_r.high_cnt - 1'b1;
      st_nxt.high_settle = (st_r.high_cnt != 1);
    end
    ev[EV_SETTLED] = (st_r.low_settle || st_r.high_settle) && !st_nxt.low_settle && !st_nxt.high_settle;

    // wake speed follows the awake low side configuration
    st_nxt.fast_wake = (!cfg_ls.en || cfg_ls.fp) && (!cfg_lm.en || cfg_lm.fp);  // [RQ4] [RQ5] [RQ6]

    // sleep and wake sequencing
    case (st_r.pwr)
      PS_ACTIVE: begin
        if (sleep_go || (i_isr_done && st_r.pwr_ctrl[B_ISR_SLEEP])) begin  // [RQ7]
          st_nxt.pwr = PS_DEEP;
        end
      end
      PS_DEEP: begin
        if (i_wake) begin
          st_nxt.pwr      = PS_WAKE;
          st_nxt.wake_cnt = st_r.fast_wake ? FAST_CNT : SLOW_CNT;           // [RQ4] [RQ5]
        end
      end
      PS_WAKE: begin
        st_nxt.wake_cnt = st_r.wake_cnt - 1'b1;
        if (st_r.wake_cnt == 1) begin
          st_nxt.pwr = PS_ACTIVE;
        end
      end
      default: st_nxt.pwr = PS_ACTIVE;
    endcase
    st_nxt.units = units_dec;

    // events: only live units report; the low side is blind while settling
    if (!st_r.low_settle) begin                                            // [RQ1]
      ev[EV_LOW_SUP] = i_trips.low_sup && (st_r.units.low_sup != SSMC_OFF);
      ev[EV_LOW_MON] = i_trips.low_mon && (st_r.units.low_mon != SSMC_OFF);
    end
    if (!st_r.high_settle) begin
      ev[EV_HIGH_SUP] = i_trips.high_sup && (st_r.units.high_sup != SSMC_OFF);
      ev[EV_HIGH_MON] = i_trips.high_mon && (st_r.units.high_mon != SSMC_OFF);
    end
    st_nxt.por = (ev[EV_LOW_SUP] && st_r.low_ctrl[B_SUP_RST]) ||           // [RQ8]
                 (ev[EV_LOW_MON] && st_r.low_ctrl[B_MON_RST]) ||
                 (ev[EV_HIGH_SUP] && st_r.high_ctrl[B_SUP_RST]) ||
                 (ev[EV_HIGH_MON] && st_r.high_ctrl[B_MON_RST]) ||
                 (st_r.high_ctrl[B_OVP_EN] && i_trips.supply_ovp &&          // [RQ9]
                  st_r.units.high_mon != SSMC_OFF);
    // routed to reset means not reported as an interrupt
    ev[EV_LOW_SUP]  = ev[EV_LOW_SUP] && !st_r.low_ctrl[B_SUP_RST];         // [RQ8]
    ev[EV_LOW_MON]  = ev[EV_LOW_MON] && !st_r.low_ctrl[B_MON_RST];
    ev[EV_HIGH_SUP] = ev[EV_HIGH_SUP] && !st_r.high_ctrl[B_SUP_RST];
    ev[EV_HIGH_MON] = ev[EV_HIGH_MON] && !st_r.high_ctrl[B_MON_RST];
    // a new event outranks a clear in the same cycle
    st_nxt.irq_stat = (st_r.irq_stat & ~clr) | ev;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      st_r           <= '0;
      st_r.low_ctrl  <= RST_LOW_CTRL;
      st_r.high_ctrl <= RST_HIGH_CTRL;
      st_r.pwr_ctrl  <= RST_PWR_CTRL;
      st_r.irq_en    <= RST_IRQ_EN;
      st_r.pwr       <= PS_ACTIVE;
      st_r.units     <= '{SSMC_OFF, SSMC_OFF, SSMC_OFF, SSMC_OFF};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_axi.awready = !st_r.aw_got && !st_r.bvalid;
  assign o_axi.wready  = !st_r.w_got && !st_r.bvalid;
  assign o_axi.bvalid  = st_r.bvalid;
  assign o_axi.bresp   = st_r.bresp;
  assign o_axi.arready = !st_r.rvalid;
  assign o_axi.rvalid  = st_r.rvalid;
  assign o_axi.rdata   = st_r.rdata;
  assign o_axi.rresp   = st_r.rresp;
  assign o_units       = st_r.units;
  assign o_deep_sleep  = (st_r.pwr == PS_DEEP);
  assign o_cpu_hold    = (st_r.pwr == PS_WAKE);
  assign o_fast_wake   = st_r.fast_wake;
  assign o_por         = st_r.por;
  assign o_irq         = |(st_r.irq_stat & st_r.irq_en);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_low_blind;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.low_settle && !i_trips.high_sup && !i_trips.high_mon && !i_trips.supply_ovp |=> !o_por;
  endproperty
  a_low_blind: assert property (p_low_blind) else $error("low side event passed while settling"); // [RQ1]

  property p_fast_settle;
    @(posedge i_mclk) disable iff (!i_rst_b)
    wr_go && st_r.awaddr == OFF_LOW_CTRL && wr_val[B_SUP_EN] && wr_val[B_SUP_FP]
      |=> st_r.low_settle [*8] ##[235:245] !st_r.low_settle;
  endproperty
  a_fast_settle: assert property (p_fast_settle) else $error("full performance settle not 250 cycles"); // [RQ2]

  property p_slow_wake;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.pwr == PS_DEEP && i_wake && !st_r.fast_wake |=> o_cpu_hold && st_r.wake_cnt == SLOW_CNT;
  endproperty
  a_slow_wake: assert property (p_slow_wake) else $error("slow wake not loaded"); // [RQ4]

  property p_fast_wake;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.pwr == PS_DEEP && i_wake && st_r.fast_wake |=> o_cpu_hold [*8] ##[240:245] !o_cpu_hold;
  endproperty
  a_fast_wake: assert property (p_fast_wake) else $error("fast wake hold not 250 cycles"); // [RQ5]

  property p_normal_slow;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.pwr == PS_ACTIVE && $stable(st_r.low_ctrl) &&
      (st_r.units.low_sup == SSMC_NORM || st_r.units.low_mon == SSMC_NORM) |-> !o_fast_wake;
  endproperty
  a_normal_slow: assert property (p_normal_slow) else $error("normal low unit with fast wake"); // [RQ6]

  property p_isr_sleep;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.pwr == PS_ACTIVE && i_isr_done && st_r.pwr_ctrl[B_ISR_SLEEP] |=> o_deep_sleep;
  endproperty
  a_isr_sleep: assert property (p_isr_sleep) else $error("no deep sleep at isr exit"); // [RQ7]

  property p_low_route;
    @(posedge i_mclk) disable iff (!i_rst_b)
    i_trips.low_mon && !st_r.low_settle && st_r.units.low_mon != SSMC_OFF
      |=> (o_por || st_r.irq_stat[EV_LOW_MON]);
  endproperty
  a_low_route: assert property (p_low_route) else $error("low monitor event lost"); // [RQ8]

  property p_ovp;
    @(posedge i_mclk) disable iff (!i_rst_b)
    st_r.high_ctrl[B_OVP_EN] && i_trips.supply_ovp && st_r.units.high_mon != SSMC_OFF |=> o_por;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage without reset"); // [RQ9]

  property p_high_auto_off;
    @(posedge i_mclk) disable iff (!i_rst_b)
    $past(st_r.pwr) == PS_DEEP && st_r.pwr == PS_DEEP && $stable(st_r.high_ctrl) &&
      st_r.high_ctrl[B_AUTO] && !st_r.high_ctrl[B_MON_FP] |-> o_units.high_mon == SSMC_OFF;
  endproperty
  a_high_auto_off: assert property (p_high_auto_off) else $error("auto supply monitor awake in sleep"); // [RQ10]

  property p_disabled_off;
    @(posedge i_mclk) disable iff (!i_rst_b)
    !st_r.low_ctrl[B_SUP_EN] && $stable(st_r.low_ctrl) |-> o_units.low_sup == SSMC_OFF;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled supervisor not off"); // [RQ13]

  property p_manual_drop;
    @(posedge i_mclk) disable iff (!i_rst_b)
    $past(st_r.pwr) == PS_DEEP && st_r.pwr == PS_DEEP && $stable(st_r.high_ctrl) &&
      !st_r.high_ctrl[B_AUTO] && !st_r.high_ctrl[B_SUP_KEEP] |-> o_units.high_sup == SSMC_OFF;
  endproperty
  a_manual_drop: assert property (p_manual_drop) else $error("manual supervisor kept in sleep"); // [RQ11] [RQ14]

endmodule

// [core/ssmc_unit_mode.sv]
/*
  Mode decoder of one supervisor or monitor unit.
  Assumes the caller supplies the unit's configuration and the sleep state.
*/
`timescale 1ns/1ps
module ssmc_unit_mode (
  // configuration
  input  wire ssmc_pkg::ssmc_unit_cfg_t i_cfg,
  input  wire logic                     i_deep,
  // decoded mode
  output ssmc_pkg::ssmc_mode_t          o_mode
);
  import ssmc_pkg::*;

  ssmc_mode_t awake_mode;

  always_comb begin
    awake_mode = !i_cfg.en ? SSMC_OFF : (i_cfg.fp ? SSMC_FULL : SSMC_NORM);   // [RQ13]
    if (!i_deep) begin
      o_mode = awake_mode;
    end else if (i_cfg.auto_ctl) begin
      // automatic control steps one level down, and only with the keep bit set
      o_mode = (i_cfg.keep && awake_mode == SSMC_FULL) ? SSMC_NORM : SSMC_OFF;   // [RQ14] [RQ10] [RQ11]
    end else begin
      o_mode = i_cfg.keep ? awake_mode : SSMC_OFF;                        // [RQ14] [RQ11]
    end
  end

endmodule

// [verif/ssmc_tb.sv]
/*
  Self-checking bench of the supply supervisor mode control top.
  Assumes ssmc_pkg and ssmc_top are compiled first; the bench is the only bus master.
*/
`timescale 1ns/1ps
module testbench;
  import ssmc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  localparam int SC = 40;
  logic          i_mclk = 1'b0;
  logic          i_rst_b = 1'b0;
  logic          isr = 1'b0;
  logic          wake = 1'b0;
  ssmc_axi_req_t axi = '0;
  ssmc_axi_rsp_t o_axi;
  ssmc_trips_t   trp = '0;
  ssmc_units_t   o_units;
  logic          o_deep_sleep, o_cpu_hold, o_fast_wake, o_por, o_irq;
  int            n_fail = 0, n_tests = 0, cyc = 0, npor = 0, p;
  logic [31:0]   rv;
  logic [1:0]    rsp;
  always #4 i_mclk = ~i_mclk;
  ssmc_top #(.SLOW_CYC(SC)) dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_axi(axi), .o_axi(o_axi),
    .i_trips(trp), .i_isr_done(isr), .i_wake(wake), .o_units(o_units), .o_deep_sleep(o_deep_sleep),
    .o_cpu_hold(o_cpu_hold), .o_fast_wake(o_fast_wake), .o_por(o_por), .o_irq(o_irq));
  // hang guard well above the few thousand cycles the tests need
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (o_por === 1'b1) npor <= npor + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge i_mclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] u(ssmc_mode_t a, ssmc_mode_t b, ssmc_mode_t c, ssmc_mode_t d);
    return {20'h0, a, b, c, d};
  endfunction
  // aw and w offered together, each dropped when taken; bready and rready stay up between transfers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi.awvalid <= 1'b1; axi.awaddr <= a; axi.wvalid <= 1'b1; axi.wdata <= d;
    axi.wstrb <= 4'hF; axi.bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (axi.awvalid && o_axi.awready) axi.awvalid <= 1'b0;
      if (axi.wvalid && o_axi.wready) axi.wvalid <= 1'b0;
    end while (!(o_axi.bvalid === 1'b1));
    rsp = o_axi.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    axi.arvalid <= 1'b1; axi.araddr <= a; axi.rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (axi.arvalid && o_axi.arready) axi.arvalid <= 1'b0;
    end while (!(o_axi.rvalid === 1'b1));
    rv = o_axi.rdata; rsp = o_axi.rresp;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(OFF_LOW_CTRL); chk(rv, 32'h003);
    rd(OFF_HIGH_CTRL); chk(rv, 32'h0CB);
    rd(8'h40); chk({rv[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'hFFFFFFFF); chk(rsp, RESP_SLVERR);
    chk(o_units, u(SSMC_NORM, SSMC_OFF, SSMC_NORM, SSMC_NORM));
    chk(o_fast_wake, 1'b0);
  endtask
  task automatic t_settle;
    wr(OFF_LOW_CTRL, 32'h007); chk(rsp, RESP_OKAY); cy(1);
    chk(o_units[11:9], SSMC_FULL);
    chk(o_fast_wake, 1'b1);
    cy(150); rd(OFF_STATUS); chk(rv & 32'h1, 32'h1);
    cy(120); rd(OFF_STATUS); chk(rv & 32'h3, 32'h0);
    wr(OFF_LOW_CTRL, 32'h000); cy(1);
    chk(o_fast_wake, 1'b1);
    wr(OFF_LOW_CTRL, 32'h003); rd(OFF_STATUS); chk(rv & 32'h1, 32'h1);
    cy(SC + 5); rd(OFF_STATUS); chk(rv & 32'h1, 32'h0);
    chk(o_fast_wake, 1'b0);
    // a core level change alone must reopen the low side settle window
    wr(OFF_PWR_CTRL, 32'hC); rd(OFF_STATUS); chk(rv & 32'h1, 32'h1);
    rd(OFF_PWR_CTRL); chk(rv, 32'hC);
    wr(OFF_PWR_CTRL, 32'h0);
  endtask
  // configure, wait out settling, sleep, check decoded units, wake and time the hold
  task automatic t_sleep(input logic [8:0] lo, input logic [8:0] hi, input logic [31:0] eu,
                         input logic by_isr, input int h);
    int n;
    wr(OFF_LOW_CTRL, {23'h0, lo}); wr(OFF_HIGH_CTRL, {23'h0, hi});
    do rd(OFF_STATUS); while (rv[1:0] !== 2'b00);
    if (by_isr) begin
      wr(OFF_PWR_CTRL, 32'h1); isr <= 1'b1; cy(1); isr <= 1'b0;
    end else wr(OFF_PWR_CTRL, 32'h2);
    cy(3); chk(o_deep_sleep, 1'b1);
    chk(o_units, eu);
    wake <= 1'b1; cy(1); wake <= 1'b0; n = 0;
    do begin cy(1); n++; end while (o_cpu_hold === 1'b1 && n < 400);
    chk(n >= h - 2 && n <= h + 3, 1'b1);
    chk(o_deep_sleep, 1'b0);
    wr(OFF_PWR_CTRL, 32'h0);
  endtask
  task automatic t_events;
    wr(OFF_IRQ_EN, 32'h1); wr(OFF_LOW_CTRL, 32'h001); cy(60);
    trp.low_sup <= 1'b1; cy(1); trp.low_sup <= 1'b0; cy(2);
    chk(o_irq, 1'b1);
    rd(OFF_IRQ_STAT); chk(rv & 32'h1, 32'h1);
    wr(OFF_IRQ_CLR, 32'h1); cy(1); chk(o_irq, 1'b0);
    wr(OFF_LOW_CTRL, 32'h041); cy(60); p = npor;
    trp.low_sup <= 1'b1; cy(1); trp.low_sup <= 1'b0; cy(3);
    chk(npor - p, 1);
    chk(o_irq, 1'b0);
    wr(OFF_HIGH_CTRL, 32'h1CB); cy(60); p = npor;
    trp.supply_ovp <= 1'b1; cy(1); trp.supply_ovp <= 1'b0; cy(3);
    chk(npor - p, 1);
  endtask
  initial begin
    cy(10);
    i_rst_b <= 1'b1;
    cy(2);
    t_reset();
    t_settle();
    t_sleep(9'h003, 9'h0CB, u(SSMC_NORM, SSMC_OFF, SSMC_NORM, SSMC_NORM), 1'b0, SC);
    t_sleep(9'h001, 9'h0EB, u(SSMC_OFF, SSMC_OFF, SSMC_OFF, SSMC_OFF), 1'b1, SC);
    t_sleep(9'h027, 9'h0CB, u(SSMC_NORM, SSMC_OFF, SSMC_NORM, SSMC_NORM), 1'b0, 250);
    t_sleep(9'h025, 9'h0C9, u(SSMC_OFF, SSMC_OFF, SSMC_OFF, SSMC_NORM), 1'b1, 250);
    t_events();
    give_verdict();
  end
endmodule
